// ---- rrsm_role_fsm.sv ----
`timescale 1ns/1ps
module rrsm_role_fsm #(
  parameter int unsigned LINK_LOSS_CYC = rrsm_pkg::LINK_LOSS_CYC,
  parameter int unsigned DROP_LOSS_CYC = rrsm_pkg::DROP_LOSS_CYC
) (
  // clock, reset, scan enable
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              scan,
  // own status
  input  wire logic              running,
  input  wire logic              online,
  input  wire logic              start_permit,
  input  wire logic              task_halted,
  input  wire logic              selector_b,
  input  wire logic              maint_mode,
  input  wire logic              swap_cmd,
  input  wire logic              simul_start,
  // links (asynchronous pins)
  input  wire logic              hsby_link_ok,
  input  wire logic              ring_link_ok,
  input  wire logic              ring_control,
  input  wire logic              drop_seen,
  // mismatch and allow flags
  input  wire logic              fw_mismatch,
  input  wire logic              fw_allow,
  input  wire logic              logic_mismatch,
  input  wire logic              logic_allow,
  input  wire logic              mod_mismatch,
  input  wire logic              mod_allow,
  input  wire logic              safe_mismatch,
  // counterpart as received
  input  wire rrsm_pkg::rrsm_role_t peer_role,
  input  wire logic              peer_running,
  input  wire logic              peer_tasks_ok,
  input  wire logic              peer_drop_ok,
  input  wire logic              peer_selector_b,
  input  wire logic              peer_maint_mode,
  input  wire logic              peer_swap_cmd,
  // published state
  output rrsm_pkg::rrsm_role_t   role,
  output logic                   drops_healthy,
  output logic                   hsby_lost
);
  typedef struct packed {
    logic [1:0]           hs_sync;
    logic [1:0]           rg_sync;
    logic [1:0]           dr_sync;
    logic                 run_d;
    rrsm_pkg::rrsm_role_t role;
  } rrsm_st_t;

  rrsm_st_t st;
  rrsm_st_t next_st;

  logic hs_ok;
  logic rg_ok;
  logic run_stop;
  logic mism_ok;
  logic safe_ok;
  logic peer_comm_lost;
  logic adapters_lost;

  assign hs_ok = st.hs_sync[1];
  assign rg_ok = st.rg_sync[1];

  rrsm_loss_timer #(.LIMIT(LINK_LOSS_CYC)) u_link_tmr (
    .clk     (clk),
    .rst     (rst),
    .present (hs_ok),
    .tick    (1'b1),
    .lost    (hsby_lost)
  );

  logic drop_lost;
  rrsm_loss_timer #(.LIMIT(DROP_LOSS_CYC)) u_drop_tmr (
    .clk     (clk),
    .rst     (rst),
    .present (st.dr_sync[1]),
    .tick    (1'b1),
    .lost    (drop_lost)
  );
  assign drops_healthy = !drop_lost;

  // safe-part modification tolerated only with both units in safety mode
  assign safe_ok = !safe_mismatch || (safe_mismatch == rrsm_pkg::SAFE_MISMATCH_ON
                   && !maint_mode && !peer_maint_mode);
  assign mism_ok = (!fw_mismatch || fw_allow) && (!logic_mismatch || logic_allow)
                   && (!mod_mismatch || mod_allow) && safe_ok;
  assign run_stop       = st.run_d && !running;
  assign peer_comm_lost = !hs_ok && !rg_ok;
  assign adapters_lost  = !drops_healthy && peer_drop_ok;

  always_comb begin
    next_st         = st;
    next_st.hs_sync = {st.hs_sync[0], hsby_link_ok};
    next_st.rg_sync = {st.rg_sync[0], ring_link_ok};
    next_st.dr_sync = {st.dr_sync[0], drop_seen};
    if (scan) begin
      next_st.run_d = running;
      if (run_stop && st.role != rrsm_pkg::RRSM_STARTING) begin
        next_st.role = rrsm_pkg::RRSM_STOP;
      end else begin
        case (st.role)
          rrsm_pkg::RRSM_STARTING: begin
            // stop-to-run arrives via simul_start; same selector simultaneous: wait
            if (simul_start && selector_b == peer_selector_b && hs_ok) begin
              next_st.role = rrsm_pkg::RRSM_WAIT;
            end else if (simul_start && online && running && hs_ok
                         && selector_b == rrsm_pkg::SELECTOR_A) begin
              next_st.role = rrsm_pkg::RRSM_PRIMARY;
            end else begin
              next_st.role = rrsm_pkg::RRSM_WAIT;
            end
          end
          rrsm_pkg::RRSM_WAIT: begin
            if (running && online && hs_ok && peer_role == rrsm_pkg::RRSM_PRIMARY
                && mism_ok) begin
              next_st.role = rrsm_pkg::RRSM_STANDBY;
            end else if (online && start_permit
                         && (ring_control || (hs_ok && !peer_running))) begin
              next_st.role = rrsm_pkg::RRSM_PRIMARY;
            end
          end
          rrsm_pkg::RRSM_STANDBY: begin
            if ((hsby_lost && rg_ok) || (mod_mismatch && !mod_allow)
                || (fw_mismatch && !fw_allow) || !safe_ok) begin
              next_st.role = rrsm_pkg::RRSM_WAIT;
            end else if (peer_role == rrsm_pkg::RRSM_WAIT
                         || peer_role == rrsm_pkg::RRSM_STANDBY) begin
              next_st.role = rrsm_pkg::RRSM_PRIMARY;
            end else if (peer_comm_lost) begin
              next_st.role = rrsm_pkg::RRSM_PRIMARY;
            end else if (peer_role == rrsm_pkg::RRSM_PRIMARY && peer_swap_cmd) begin
              next_st.role = rrsm_pkg::RRSM_PRIMARY;
            end
          end
          rrsm_pkg::RRSM_PRIMARY: begin
            // standby is reached only through wait, so every exit here lands in wait
            if (adapters_lost && peer_role == rrsm_pkg::RRSM_STANDBY) begin
              next_st.role = rrsm_pkg::RRSM_WAIT;
            end else if (selector_b == rrsm_pkg::SELECTOR_B && peer_selector_b
                         && peer_role == rrsm_pkg::RRSM_PRIMARY) begin
              next_st.role = rrsm_pkg::RRSM_WAIT;
            end else if (task_halted && peer_role == rrsm_pkg::RRSM_STANDBY
                         && peer_tasks_ok) begin
              next_st.role = rrsm_pkg::RRSM_WAIT;
            end else if (swap_cmd && peer_role == rrsm_pkg::RRSM_STANDBY && mism_ok) begin
              next_st.role = rrsm_pkg::RRSM_WAIT;
            end
          end
          rrsm_pkg::RRSM_STOP: begin
            if (running) begin
              next_st.role = rrsm_pkg::RRSM_WAIT;
            end
          end
          default: next_st.role = rrsm_pkg::RRSM_WAIT;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st      <= '0;
      st.role <= rrsm_pkg::RRSM_STARTING;
    end else begin
      st <= next_st;
    end
  end

  assign role = st.role;

  property p_stop_on_run_stop;
    @(posedge clk) disable iff (rst)
      scan && run_stop && st.role != rrsm_pkg::RRSM_STARTING |=> role == rrsm_pkg::RRSM_STOP;
  endproperty
  a_stop_on_run_stop: assert property (p_stop_on_run_stop)
    else $error("run to stop did not reach stop role");

  property p_no_direct_primary_to_standby;
    @(posedge clk) disable iff (rst)
      role == rrsm_pkg::RRSM_PRIMARY |=> role != rrsm_pkg::RRSM_STANDBY;
  endproperty
  a_no_direct_primary_to_standby: assert property (p_no_direct_primary_to_standby)
    else $error("primary went straight to standby");

  property p_wait_to_standby_cause;
    @(posedge clk) disable iff (rst)
      $past(role) == rrsm_pkg::RRSM_WAIT && role == rrsm_pkg::RRSM_STANDBY
      |-> $past(mism_ok) && $past(running) && $past(peer_role) == rrsm_pkg::RRSM_PRIMARY;
  endproperty
  a_wait_to_standby_cause: assert property (p_wait_to_standby_cause)
    else $error("standby entered without its preconditions");

  property p_standby_peer_wait;
    @(posedge clk) disable iff (rst)
      scan && role == rrsm_pkg::RRSM_STANDBY && !run_stop && !hsby_lost && safe_ok
      && (!mod_mismatch || mod_allow) && (!fw_mismatch || fw_allow)
      && peer_role == rrsm_pkg::RRSM_WAIT |=> role == rrsm_pkg::RRSM_PRIMARY;
  endproperty
  a_standby_peer_wait: assert property (p_standby_peer_wait)
    else $error("standby did not take primary when peer waits");

  property p_standby_link_loss;
    @(posedge clk) disable iff (rst)
      scan && role == rrsm_pkg::RRSM_STANDBY && !run_stop && hsby_lost && rg_ok
      |=> role == rrsm_pkg::RRSM_WAIT;
  endproperty
  a_standby_link_loss: assert property (p_standby_link_loss)
    else $error("standby did not drop to wait on link loss");

  property p_fw_disallowed;
    @(posedge clk) disable iff (rst)
      scan && role == rrsm_pkg::RRSM_STANDBY && !run_stop && fw_mismatch && !fw_allow
      |=> role == rrsm_pkg::RRSM_WAIT;
  endproperty
  a_fw_disallowed: assert property (p_fw_disallowed)
    else $error("standby kept role with disallowed firmware update");

  property p_primary_swap;
    @(posedge clk) disable iff (rst)
      scan && role == rrsm_pkg::RRSM_PRIMARY && !run_stop && swap_cmd && mism_ok
      && peer_role == rrsm_pkg::RRSM_STANDBY |=> role == rrsm_pkg::RRSM_WAIT;
  endproperty
  a_primary_swap: assert property (p_primary_swap)
    else $error("swap did not release primary");

  property p_hold_without_scan;
    @(posedge clk) disable iff (rst) !scan |=> $stable(role);
  endproperty
  a_hold_without_scan: assert property (p_hold_without_scan)
    else $error("role changed outside a scan");

endmodule : rrsm_role_fsm

// ---- rrsm_pkg.sv ----
package rrsm_pkg;

  typedef enum logic [2:0] {
    RRSM_STARTING,
    RRSM_WAIT,
    RRSM_STANDBY,
    RRSM_PRIMARY,
    RRSM_STOP
  } rrsm_role_t;

  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned LINK_LOSS_SEC   = 3;
  localparam int unsigned DROP_LOSS_SEC   = 3;
  localparam int unsigned LINK_LOSS_CYC   = LINK_LOSS_SEC * CLK_HZ;
  localparam int unsigned DROP_LOSS_CYC   = DROP_LOSS_SEC * CLK_HZ;
  localparam logic        SAFE_MISMATCH_ON = 1'b1;
  localparam logic        SELECTOR_A       = 1'b0;
  localparam logic        SELECTOR_B       = 1'b1;

endpackage : rrsm_pkg

// ---- rrsm_loss_timer.sv ----
`timescale 1ns/1ps
// counts cycles a condition is absent; flags lost once the count passes the limit
module rrsm_loss_timer #(
  parameter int unsigned LIMIT = 120_000_000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // condition
  input  wire logic present,
  input  wire logic tick,
  output logic      lost
);
  if (LIMIT < 1) begin : g_bad_limit
    $error("rrsm_loss_timer: LIMIT must be at least 1");
  end

  localparam int W = $clog2(LIMIT + 1) + 1;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         lost;
  } rrsm_tmr_t;

  rrsm_tmr_t st;
  rrsm_tmr_t next_st;

  always_comb begin
    next_st = st;
    if (present) begin
      next_st.cnt  = '0;
      next_st.lost = 1'b0;
    end else if (tick && !st.lost) begin
      next_st.cnt = st.cnt + W'(1);
      if (st.cnt >= W'(LIMIT)) begin
        next_st.lost = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lost = st.lost;

  property p_no_lost_when_present;
    @(posedge clk) disable iff (rst) present |=> !lost;
  endproperty
  a_no_lost_when_present: assert property (p_no_lost_when_present)
    else $error("lost flag raised while condition present");

endmodule : rrsm_loss_timer

// ---- rrsm_peer_model.sv ----
`timescale 1ns/1ps
// counterpart unit: publishes its role and status one clock behind the bench controls,
// the way a status frame arriving from the far unit would
module rrsm_peer_model (
  // clock
  input  wire logic                 clk,
  // controls from the bench: running, tasks_ok, drop_ok, selector_b, maint, swap
  input  wire rrsm_pkg::rrsm_role_t set_role,
  input  wire logic [5:0]           set_status,
  // status as received by the unit
  output rrsm_pkg::rrsm_role_t      peer_role,
  output logic                      peer_running,
  output logic                      peer_tasks_ok,
  output logic                      peer_drop_ok,
  output logic                      peer_selector_b,
  output logic                      peer_maint_mode,
  output logic                      peer_swap_cmd
);
  always_ff @(posedge clk) begin
    peer_role <= set_role;
    {peer_running, peer_tasks_ok, peer_drop_ok} <= set_status[5:3];
    {peer_selector_b, peer_maint_mode, peer_swap_cmd} <= set_status[2:0];
  end
endmodule : rrsm_peer_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic clk, rst, scan, running, online, start_permit, task_halted, selector_b, maint_mode;
  logic swap_cmd, simul_start, hsby_link_ok, ring_link_ok, ring_control, drop_seen;
  logic fw_mismatch, fw_allow, logic_mismatch, logic_allow, mod_mismatch, mod_allow;
  logic safe_mismatch, peer_running, peer_tasks_ok, peer_drop_ok, peer_selector_b;
  logic peer_maint_mode, peer_swap_cmd, drops_healthy, hsby_lost;
  logic [5:0]            p_stat;
  logic [31:0]           r;
  rrsm_pkg::rrsm_role_t  p_role, peer_role, role;
  integer                seed, n_errors, comparisons, cycles, i;

  rrsm_role_fsm #(.LINK_LOSS_CYC(20), .DROP_LOSS_CYC(20)) i_rrsm_role_fsm (
    .clk(clk), .rst(rst), .scan(scan), .running(running), .online(online),
    .start_permit(start_permit), .task_halted(task_halted), .selector_b(selector_b),
    .maint_mode(maint_mode), .swap_cmd(swap_cmd), .simul_start(simul_start),
    .hsby_link_ok(hsby_link_ok), .ring_link_ok(ring_link_ok), .ring_control(ring_control),
    .drop_seen(drop_seen), .fw_mismatch(fw_mismatch), .fw_allow(fw_allow),
    .logic_mismatch(logic_mismatch), .logic_allow(logic_allow), .mod_mismatch(mod_mismatch),
    .mod_allow(mod_allow), .safe_mismatch(safe_mismatch), .peer_role(peer_role),
    .peer_running(peer_running), .peer_tasks_ok(peer_tasks_ok), .peer_drop_ok(peer_drop_ok),
    .peer_selector_b(peer_selector_b), .peer_maint_mode(peer_maint_mode),
    .peer_swap_cmd(peer_swap_cmd), .role(role), .drops_healthy(drops_healthy),
    .hsby_lost(hsby_lost));

  rrsm_peer_model i_rrsm_peer_model (
    .clk(clk), .set_role(p_role), .set_status(p_stat), .peer_role(peer_role),
    .peer_running(peer_running), .peer_tasks_ok(peer_tasks_ok), .peer_drop_ok(peer_drop_ok),
    .peer_selector_b(peer_selector_b), .peer_maint_mode(peer_maint_mode),
    .peer_swap_cmd(peer_swap_cmd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk_role(input rrsm_pkg::rrsm_role_t got, input rrsm_pkg::rrsm_role_t exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: role %0d, expected %0d", $time, got, exp);
    end
  endtask : chk_role

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: status bit %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit

  function automatic rrsm_pkg::rrsm_role_t exp_wait(input logic [2:0] m, input logic [2:0] a);
    return ((m & ~a) == 3'h0) ? rrsm_pkg::RRSM_STANDBY : rrsm_pkg::RRSM_WAIT;
  endfunction : exp_wait

  // settle time covers the two-stage link synchronisers, plus a random scan spacing
  task automatic scan_expect(input rrsm_pkg::rrsm_role_t exp);
    repeat (2 + ($unsigned($random(seed)) % 3)) @(posedge clk);
    scan <= 1'b1;
    @(posedge clk) scan <= 1'b0;
    @(posedge clk) chk_role(role, exp);
  endtask : scan_expect

  task automatic do_reset;
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  initial begin
    {seed, n_errors, comparisons, cycles} = {32'h6d0c, 32'h0, 32'h0, 32'h0};
    {rst, scan, running, online, hsby_link_ok, ring_link_ok, drop_seen} = 7'h5f;
    {fw_allow, logic_allow, mod_allow, start_permit, task_halted, selector_b} = 6'h38;
    {maint_mode, swap_cmd, simul_start, ring_control, fw_mismatch} = 5'h0;
    {logic_mismatch, mod_mismatch, safe_mismatch} = 3'h0;
    p_role = rrsm_pkg::RRSM_PRIMARY;
    p_stat = 6'h3c;
    do_reset;
    chk_role(role, rrsm_pkg::RRSM_STARTING);
    chk_bit(drops_healthy, 1'b1);
    chk_bit(hsby_lost, 1'b0);
    scan_expect(rrsm_pkg::RRSM_WAIT);
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      {fw_mismatch, logic_mismatch, mod_mismatch} <= r[2:0];
      {fw_allow, logic_allow, mod_allow} <= r[5:3];
      scan_expect(exp_wait(r[2:0], r[5:3]));
      if (role === rrsm_pkg::RRSM_STANDBY) begin
        if (r[6]) {mod_mismatch, mod_allow} <= 2'b10;
        else {fw_mismatch, fw_allow} <= 2'b10;
        scan_expect(rrsm_pkg::RRSM_WAIT);
      end
    end
    {fw_mismatch, logic_mismatch, mod_mismatch} <= 3'h0;
    scan_expect(rrsm_pkg::RRSM_STANDBY);
    p_role <= rrsm_pkg::RRSM_WAIT;
    scan_expect(rrsm_pkg::RRSM_PRIMARY);
    p_role <= rrsm_pkg::RRSM_STANDBY;
    swap_cmd <= 1'b1;
    scan_expect(rrsm_pkg::RRSM_WAIT);
    swap_cmd <= 1'b0;
    p_role <= rrsm_pkg::RRSM_PRIMARY;
    scan_expect(rrsm_pkg::RRSM_STANDBY);
    p_stat[0] <= 1'b1;
    scan_expect(rrsm_pkg::RRSM_PRIMARY);
    p_stat[0] <= 1'b0;
    selector_b <= 1'b1;
    scan_expect(rrsm_pkg::RRSM_WAIT);
    selector_b <= 1'b0;
    p_role <= rrsm_pkg::RRSM_WAIT;
    {start_permit, ring_control} <= 2'b11;
    scan_expect(rrsm_pkg::RRSM_PRIMARY);
    p_role <= rrsm_pkg::RRSM_STANDBY;
    {start_permit, ring_control, task_halted} <= 3'b001;
    scan_expect(rrsm_pkg::RRSM_WAIT);
    p_role <= rrsm_pkg::RRSM_PRIMARY;
    task_halted <= 1'b0;
    scan_expect(rrsm_pkg::RRSM_STANDBY);
    hsby_link_ok <= 1'b0;
    repeat (30) @(posedge clk);
    chk_bit(hsby_lost, 1'b1);
    scan_expect(rrsm_pkg::RRSM_WAIT);
    hsby_link_ok <= 1'b1;
    repeat (4) @(posedge clk);
    scan_expect(rrsm_pkg::RRSM_STANDBY);
    {hsby_link_ok, ring_link_ok} <= 2'b00;
    repeat (30) @(posedge clk);
    scan_expect(rrsm_pkg::RRSM_PRIMARY);
    {hsby_link_ok, ring_link_ok, drop_seen} <= 3'b110;
    repeat (30) @(posedge clk);
    chk_bit(drops_healthy, 1'b0);
    p_role <= rrsm_pkg::RRSM_STANDBY;
    scan_expect(rrsm_pkg::RRSM_WAIT);
    drop_seen <= 1'b1;
    repeat (4) @(posedge clk);
    chk_bit(drops_healthy, 1'b1);
    running <= 1'b0;
    scan_expect(rrsm_pkg::RRSM_STOP);
    running <= 1'b1;
    p_role <= rrsm_pkg::RRSM_PRIMARY;
    scan_expect(rrsm_pkg::RRSM_WAIT);
    scan_expect(rrsm_pkg::RRSM_STANDBY);
    {safe_mismatch, p_stat[1]} <= 2'b11;
    scan_expect(rrsm_pkg::RRSM_WAIT);
    {safe_mismatch, p_stat[1], simul_start} <= 3'b001;
    p_role <= rrsm_pkg::RRSM_STARTING;
    do_reset;
    scan_expect(rrsm_pkg::RRSM_PRIMARY);
    // both on A: without the same-position rule this unit would take primary
    p_stat[2] <= 1'b0;
    do_reset;
    scan_expect(rrsm_pkg::RRSM_WAIT);
    tally_and_finish;
  end
endmodule : testbench
